/* File: rtl/wcd_core.sv */
// What this block does
// RL1: the watchdog clear operation is recognised only by its one fixed 14-bit opcode with no operands.
// RL2: executing the watchdog clear loads the watchdog count with zero.
// RL3: the same execution also clears the watchdog prescaler to zero.
// RL4: the watchdog clear sets the timeout and power-down flags and no other status bit.
// RL5: the decrement is its six-bit prefix, then a destination bit and a seven-bit address.
// RL6: the register address spans 0 to 127 and the destination is a single bit.
// RL7: the result is the register minus one, and with destination 0 it goes to the accumulator only.
// RL8: with destination 1 the result is written back to the addressed file register instead.
// RL9: the decrement updates the zero flag and leaves every other status bit alone.
// RL10: zero is set when the 8-bit result is zero and cleared otherwise, and 0x00 wraps to 0xFF.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps

module wcd_core
(
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    input  wire logic                           instr_valid,
    input  wire logic [wcd_pkg::OPCODE_W-1:0]   instr_word,
    output logic                                instr_ready,
    output logic [wcd_pkg::FILE_ADDR_W-1:0]     rf_rd_addr,
    input  wire logic [wcd_pkg::DATA_W-1:0]     rf_rd_data,
    output wcd_pkg::wcd_file_wr_s               file_wr,
    output wcd_pkg::wcd_acc_wr_s                acc_wr,
    output wcd_pkg::wcd_status_wr_s             status_wr,
    output wcd_pkg::wcd_wdt_load_s              wdt_load,
    input  wire logic [wcd_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    input  wire logic [wcd_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------

    typedef struct packed {
        wcd_pkg::wcd_phase_e                phase;
        logic                               instr_ready;
        logic                               dest_file;
        logic [wcd_pkg::FILE_ADDR_W-1:0]    rf_rd_addr;
        wcd_pkg::wcd_file_wr_s              file_wr;
        wcd_pkg::wcd_acc_wr_s               acc_wr;
        wcd_pkg::wcd_status_wr_s            status_wr;
        wcd_pkg::wcd_wdt_load_s             wdt_load;
        logic                               exec_en;
        logic                               zero;
        logic                               timeout_flag;
        logic                               powerdown_flag;
        logic                               unsupported;
        logic [15:0]                        wdt_clr_cnt;
        logic [15:0]                        dec_cnt;
        logic [wcd_pkg::DATA_W-1:0]         last_result;
        logic [wcd_pkg::FILE_ADDR_W-1:0]    last_addr;
        logic                               last_dest;
        logic                               awready;
        logic                               wready;
        logic                               aw_have;
        logic [wcd_pkg::AXI_ADDR_W-1:0]     aw_addr;
        logic                               w_have;
        logic [31:0]                        wdata;
        logic [3:0]                         wstrb;
        logic                               bvalid;
        logic [1:0]                         bresp;
        logic                               arready;
        logic                               rvalid;
        logic [31:0]                        rdata;
        logic [1:0]                         rresp;
    } wcd_state_s;

    wcd_state_s                 st;
    wcd_state_s                 next_st;
    wcd_pkg::wcd_decode_s       decode;
    logic [wcd_pkg::DATA_W-1:0] dec_result;

    // ------------------------------------------------------------
    // opcode decode
    // ------------------------------------------------------------

    wcd_decoder u_decoder
    (
        .opcode (instr_word),
        .decode (decode)
    );

    // RL7: operand minus one
    // RL10: wraps to 0xFF
    assign dec_result = rf_rd_data - wcd_pkg::DECREMENT_STEP;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------

    // bus side first, so hardware events win over a clear
    always_comb
    begin
        next_st = st;
        next_st.file_wr.en          = 1'b0;
        next_st.acc_wr.en           = 1'b0;
        next_st.status_wr           = '0;
        next_st.wdt_load.clear      = 1'b0;

        // write response retired
        if (st.bvalid && s_axi_bready)
        begin
            next_st.bvalid = 1'b0;
        end

        // address and data are caught in either order
        if (s_axi_awvalid && st.awready)
        begin
            next_st.aw_have = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready)
        begin
            next_st.w_have = 1'b1;
            next_st.wdata  = s_axi_wdata;
            next_st.wstrb  = s_axi_wstrb;
        end

        // register write once both halves are held
        if (next_st.aw_have && next_st.w_have && !next_st.bvalid)
        begin
            next_st.aw_have = 1'b0;
            next_st.w_have  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = wcd_pkg::RESP_OKAY;
            case (next_st.aw_addr)
                wcd_pkg::ADDR_CTRL:
                begin
                    if (next_st.wstrb[0])
                    begin
                        next_st.exec_en = next_st.wdata[wcd_pkg::CTRL_EXEC_EN_BIT];
                        if (next_st.wdata[wcd_pkg::CTRL_CNT_CLR_BIT])
                        begin
                            next_st.wdt_clr_cnt = '0;
                            next_st.dec_cnt     = '0;
                            next_st.unsupported = 1'b0;
                        end
                    end
                end
                wcd_pkg::ADDR_STATUS,
                wcd_pkg::ADDR_WDT_CLR_CNT,
                wcd_pkg::ADDR_DEC_CNT,
                wcd_pkg::ADDR_LAST_DEC:
                begin
                    // read-only words accept and drop the data
                    next_st.bresp = wcd_pkg::RESP_OKAY;
                end
                default:
                begin
                    next_st.bresp = wcd_pkg::RESP_SLVERR;
                end
            endcase
        end

        // read response retired, then a new read taken
        if (st.rvalid && s_axi_rready)
        begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = wcd_pkg::RESP_OKAY;
            next_st.rdata  = 32'h00000000;
            case (s_axi_araddr)
                wcd_pkg::ADDR_CTRL:
                begin
                    next_st.rdata[wcd_pkg::CTRL_EXEC_EN_BIT] = st.exec_en;
                end
                wcd_pkg::ADDR_STATUS:
                begin
                    next_st.rdata[wcd_pkg::STAT_ZERO_BIT]    = st.zero;
                    next_st.rdata[wcd_pkg::STAT_TIMEOUT_BIT] = st.timeout_flag;
                    next_st.rdata[wcd_pkg::STAT_PWRDN_BIT]   = st.powerdown_flag;
                    next_st.rdata[wcd_pkg::STAT_BUSY_BIT]    = (st.phase != wcd_pkg::ST_IDLE);
                    next_st.rdata[wcd_pkg::STAT_UNSUP_BIT]   = st.unsupported;
                end
                wcd_pkg::ADDR_WDT_CLR_CNT:
                begin
                    next_st.rdata[15:0] = st.wdt_clr_cnt;
                end
                wcd_pkg::ADDR_DEC_CNT:
                begin
                    next_st.rdata[15:0] = st.dec_cnt;
                end
                wcd_pkg::ADDR_LAST_DEC:
                begin
                    next_st.rdata[wcd_pkg::DATA_W-1:0]      = st.last_result;
                    next_st.rdata[wcd_pkg::LAST_ADDR_LSB +: wcd_pkg::FILE_ADDR_W] = st.last_addr;
                    next_st.rdata[wcd_pkg::LAST_DEST_BIT]   = st.last_dest;
                end
                default:
                begin
                    next_st.rresp = wcd_pkg::RESP_SLVERR;
                end
            endcase
        end

        // instruction execution
        case (st.phase)
            wcd_pkg::ST_IDLE:
            begin
                if (instr_valid && st.instr_ready)
                begin
                    // RL1: exact opcode only
                    if (decode.wdt_clear)
                    begin
                        // RL2: count to zero
                        next_st.wdt_load.clear     = 1'b1;
                        next_st.wdt_load.count     = wcd_pkg::WDT_COUNT_CLEAR;
                        // RL3: prescaler cleared together
                        next_st.wdt_load.prescaler = wcd_pkg::WDT_PRESC_CLEAR;
                        // RL4: set both flags
                        next_st.status_wr.flags_we       = 1'b1;
                        next_st.status_wr.timeout_flag   = 1'b1;
                        next_st.status_wr.powerdown_flag = 1'b1;
                        next_st.timeout_flag   = 1'b1;
                        next_st.powerdown_flag = 1'b1;
                        next_st.wdt_clr_cnt    = next_st.wdt_clr_cnt + wcd_pkg::COUNT_STEP;
                    end
                    // RL5: prefix selects the decrement
                    else if (decode.decrement)
                    begin
                        // RL6: operands latched
                        next_st.rf_rd_addr = decode.addr;
                        next_st.dest_file  = decode.dest_file;
                        next_st.phase      = wcd_pkg::ST_READ;
                    end
                    else
                    begin
                        // other opcodes belong elsewhere; flag them, sticky
                        next_st.unsupported = 1'b1;
                    end
                end
            end
            wcd_pkg::ST_READ:
            begin
                // register file answers combinationally to rf_rd_addr
                if (st.dest_file)
                begin
                    // RL8: file write-back
                    next_st.file_wr.en   = 1'b1;
                    next_st.file_wr.addr = st.rf_rd_addr;
                    next_st.file_wr.data = dec_result;
                end
                else
                begin
                    // RL7: accumulator only
                    next_st.acc_wr.en   = 1'b1;
                    next_st.acc_wr.data = dec_result;
                end
                // RL9: zero flag only
                next_st.status_wr.zero_we = 1'b1;
                // RL10: zero on zero result
                next_st.status_wr.zero = (dec_result == wcd_pkg::RESULT_ZERO);
                next_st.zero           = (dec_result == wcd_pkg::RESULT_ZERO);
                next_st.last_result    = dec_result;
                next_st.last_addr      = st.rf_rd_addr;
                next_st.last_dest      = st.dest_file;
                next_st.dec_cnt        = next_st.dec_cnt + wcd_pkg::COUNT_STEP;
                next_st.phase          = wcd_pkg::ST_IDLE;
            end
            default:
            begin
                next_st.phase = wcd_pkg::ST_IDLE;
            end
        endcase

        // ready terms; one write and one read in flight at most
        next_st.instr_ready = (next_st.phase == wcd_pkg::ST_IDLE) && next_st.exec_en;
        next_st.awready     = !next_st.aw_have && !next_st.bvalid;
        next_st.wready      = !next_st.w_have && !next_st.bvalid;
        next_st.arready     = !next_st.rvalid;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------

    // readies come up one edge after reset release
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st         <= '0;
            st.exec_en <= wcd_pkg::CTRL_EXEC_EN_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    // every output is a state flop
    assign instr_ready   = st.instr_ready;
    assign rf_rd_addr    = st.rf_rd_addr;
    assign file_wr       = st.file_wr;
    assign acc_wr        = st.acc_wr;
    assign status_wr     = st.status_wr;
    assign wdt_load      = st.wdt_load;
    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_arready = st.arready;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign s_axi_rvalid  = st.rvalid;

endmodule

/* File: rtl/wcd_pkg.sv */
package wcd_pkg;

    // ------------------------------------------------------------
    // instruction encodings
    // ------------------------------------------------------------
    localparam int unsigned    OPCODE_W          = 14;
    localparam logic [13:0]    WDT_CLEAR_OPCODE  = 14'h0064;
    localparam logic [5:0]     DECREMENT_PREFIX  = 6'h03;
    localparam int unsigned    PREFIX_LSB        = 8;
    localparam int unsigned    DEST_BIT          = 7;
    localparam int unsigned    FILE_ADDR_W       = 7;
    localparam int unsigned    DATA_W            = 8;
    localparam int unsigned    PRESCALER_W       = 8;

    // ------------------------------------------------------------
    // load values and arithmetic constants
    // ------------------------------------------------------------
    localparam logic [7:0]     WDT_COUNT_CLEAR   = 8'h00;
    localparam logic [7:0]     WDT_PRESC_CLEAR   = 8'h00;
    localparam logic [7:0]     DECREMENT_STEP    = 8'h01;
    localparam logic [7:0]     RESULT_ZERO       = 8'h00;
    localparam logic [15:0]    COUNT_STEP        = 16'h0001;

    // ------------------------------------------------------------
    // register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam int unsigned    AXI_ADDR_W        = 8;
    localparam logic [7:0]     ADDR_CTRL         = 8'h00;
    localparam logic [7:0]     ADDR_STATUS       = 8'h04;
    localparam logic [7:0]     ADDR_WDT_CLR_CNT  = 8'h08;
    localparam logic [7:0]     ADDR_DEC_CNT      = 8'h0C;
    localparam logic [7:0]     ADDR_LAST_DEC     = 8'h10;
    localparam int unsigned    CTRL_EXEC_EN_BIT  = 0;
    localparam int unsigned    CTRL_CNT_CLR_BIT  = 1;
    localparam logic           CTRL_EXEC_EN_RST  = 1'b1;
    localparam int unsigned    STAT_ZERO_BIT     = 0;
    localparam int unsigned    STAT_TIMEOUT_BIT  = 1;
    localparam int unsigned    STAT_PWRDN_BIT    = 2;
    localparam int unsigned    STAT_BUSY_BIT     = 3;
    localparam int unsigned    STAT_UNSUP_BIT    = 4;
    localparam int unsigned    LAST_ADDR_LSB     = 8;
    localparam int unsigned    LAST_DEST_BIT     = 15;
    localparam logic [1:0]     RESP_OKAY         = 2'h0;
    localparam logic [1:0]     RESP_SLVERR       = 2'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [0:0] {ST_IDLE, ST_READ} wcd_phase_e;

    typedef struct packed {
        logic                   wdt_clear;
        logic                   decrement;
        logic                   dest_file;
        logic [FILE_ADDR_W-1:0] addr;
    } wcd_decode_s;

    typedef struct packed {
        logic                   en;
        logic [FILE_ADDR_W-1:0] addr;
        logic [DATA_W-1:0]      data;
    } wcd_file_wr_s;

    typedef struct packed {
        logic              en;
        logic [DATA_W-1:0] data;
    } wcd_acc_wr_s;

    typedef struct packed {
        logic zero_we;
        logic zero;
        logic flags_we;
        logic timeout_flag;
        logic powerdown_flag;
    } wcd_status_wr_s;

    typedef struct packed {
        logic                   clear;
        logic [7:0]             count;
        logic [PRESCALER_W-1:0] prescaler;
    } wcd_wdt_load_s;

endpackage

/* File: rtl/wcd_decoder.sv */
`timescale 1ns/1ps

module wcd_decoder
(
    input  wire logic [wcd_pkg::OPCODE_W-1:0] opcode,
    output wcd_pkg::wcd_decode_s              decode
);

    // ------------------------------------------------------------
    // opcode match
    // ------------------------------------------------------------

    // pure decode, no state; the caller registers whatever it keeps
    always_comb
    begin
        decode = '0;
        // RL1: fixed clear opcode
        decode.wdt_clear = (opcode == wcd_pkg::WDT_CLEAR_OPCODE);
        // RL5: decrement prefix match
        decode.decrement = (opcode[wcd_pkg::OPCODE_W-1:wcd_pkg::PREFIX_LSB] == wcd_pkg::DECREMENT_PREFIX);
        // RL6: destination and address
        decode.dest_file = opcode[wcd_pkg::DEST_BIT];
        decode.addr      = opcode[wcd_pkg::FILE_ADDR_W-1:0];
    end

endmodule

/* File: sim/wcd_core_asserts.sv */
`timescale 1ns/1ps

module wcd_core_asserts
(
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic                         instr_valid,
    input  wire logic [wcd_pkg::OPCODE_W-1:0] instr_word,
    input  wire logic                         instr_ready,
    input  wire logic [6:0]                   rf_rd_addr,
    input  wire logic [7:0]                   rf_rd_data,
    input  wire wcd_pkg::wcd_file_wr_s        file_wr,
    input  wire wcd_pkg::wcd_acc_wr_s         acc_wr,
    input  wire wcd_pkg::wcd_status_wr_s      status_wr,
    input  wire wcd_pkg::wcd_wdt_load_s       wdt_load
);
    // ------------------------------------------------------------
    // instruction port checks
    // ------------------------------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic       take;
    logic       is_dec;
    logic [6:0] w_addr;

    // a word counts only when it is taken
    assign take   = instr_valid && instr_ready;
    assign is_dec = instr_word[13:8] == wcd_pkg::DECREMENT_PREFIX;
    assign w_addr = instr_word[6:0];

    clr_take_a: assert property (take && instr_word == wcd_pkg::WDT_CLEAR_OPCODE |=> wdt_load.clear)
        else $error("clear opcode gave no clear pulse");
    clr_only_a: assert property (take && instr_word != wcd_pkg::WDT_CLEAR_OPCODE |=> !wdt_load.clear)
        else $error("clear pulse from another opcode");
    wdt_zero_a: assert property (wdt_load.clear |-> wdt_load.count == 8'h00 && wdt_load.prescaler == 8'h00)
        else $error("watchdog load values not zero");
    flags_set_a: assert property (status_wr.flags_we |-> status_wr.timeout_flag && status_wr.powerdown_flag && !status_wr.zero_we && $past(take))
        else $error("status flag write wrong");
    dec_read_a: assert property (take && is_dec |=> rf_rd_addr == $past(w_addr) && !instr_ready)
        else $error("decrement read address wrong");
    dest_file_a: assert property (take && is_dec && instr_word[7] |=> ##1 file_wr.en && !acc_wr.en && file_wr.addr == $past(w_addr, 2))
        else $error("file write-back missing");
    dest_acc_a: assert property (take && is_dec && !instr_word[7] |=> ##1 acc_wr.en && !file_wr.en)
        else $error("accumulator write missing");
    dec_value_a: assert property (file_wr.en || acc_wr.en |-> (file_wr.en ? file_wr.data : acc_wr.data) == 8'($past(rf_rd_data) - 8'h01))
        else $error("decrement result wrong");
    zero_flag_a: assert property (status_wr.zero_we |-> status_wr.zero == ($past(rf_rd_data) == 8'h01) && !status_wr.flags_we)
        else $error("zero flag wrong");

    // main scenarios reached
    cover property (take && instr_word == wcd_pkg::WDT_CLEAR_OPCODE);
    cover property (file_wr.en && file_wr.data == 8'hFF);
    cover property (acc_wr.en && status_wr.zero);
endmodule

bind wcd_core wcd_core_asserts u_chk (.aclk, .aresetn, .instr_valid, .instr_word, .instr_ready, .rf_rd_addr,
    .rf_rd_data, .file_wr, .acc_wr, .status_wr, .wdt_load);

/* File: sim/wcd_rf_model.sv */
`timescale 1ns/1ps

module wcd_rf_model
(
    input  wire logic                  aclk,
    input  wire logic [6:0]            rf_rd_addr,
    output logic [7:0]                 rf_rd_data,
    input  wire wcd_pkg::wcd_file_wr_s file_wr
);
    // ------------------------------------------------------------
    // file register array
    // ------------------------------------------------------------
    logic [7:0] mem [128];

    // combinational read, the core samples it in its read cycle
    assign rf_rd_data = mem[rf_rd_addr];

    always @(posedge aclk)
        if (file_wr.en)
            mem[file_wr.addr] <= file_wr.data;

    // preload from the bench, kept off clock edges
    task automatic poke(input logic [6:0] a, input logic [7:0] v);
        mem[a] = v;
    endtask
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ps

module testbench;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic                    aclk = 1'b0;
    logic                    aresetn = 1'b0, instr_valid = 1'b0;
    logic [13:0]             instr_word = 14'h0000;
    logic [6:0]              rf_rd_addr;
    logic [7:0]              rf_rd_data;
    wcd_pkg::wcd_file_wr_s   file_wr;
    wcd_pkg::wcd_acc_wr_s    acc_wr;
    wcd_pkg::wcd_status_wr_s status_wr;
    wcd_pkg::wcd_wdt_load_s  wdt_load;
    logic [7:0]              s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]             s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic [3:0]              s_axi_wstrb = 4'hF;
    logic                    s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic                    s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic                    instr_ready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]              s_axi_bresp, s_axi_rresp;
    int                      fail_count = 0, n_checks = 0, cyc = 0;

    wcd_core DUT (.aclk, .aresetn, .instr_valid, .instr_word, .instr_ready, .rf_rd_addr, .rf_rd_data, .file_wr,
        .acc_wr, .status_wr, .wdt_load, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    wcd_rf_model rf (.aclk, .rf_rd_addr, .rf_rd_data, .file_wr);

    // 125 MHz clock; ceiling well above the run
    always #4 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            fail_count++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            #1;
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        while (!tb);
        s_axi_bready <= 1'b0;
        check(r, er);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tb;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            #1;
            ta = s_axi_arready;
            tb = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        while (!tb);
        s_axi_rready <= 1'b0;
        check(d, ed);
        check(r, er);
    endtask

    // hold a word until taken, return 1 ns after
    task automatic issue(input logic [13:0] w);
        @(posedge aclk);
        instr_valid <= 1'b1;
        instr_word <= w;
        #1;
        while (!instr_ready)
        begin
            @(posedge aclk);
            #1;
        end
        @(posedge aclk);
        instr_valid <= 1'b0;
        #1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_clear();
        issue(14'h0064);
        check(wdt_load, {1'b1, 8'h00, 8'h00});
        check(status_wr, 5'b00111);
        @(posedge aclk);
        #1;
        check(wdt_load.clear, 1'b0);
    endtask

    // near-miss opcode: no clear, flagged unknown
    task automatic t_near();
        issue(14'h0065);
        check(wdt_load.clear, 1'b0);
        rd_chk(wcd_pkg::ADDR_STATUS, 32'h16, 2'h0);
    endtask

    task automatic t_dec(input logic [6:0] a, input logic d, input logic [7:0] v);
        logic [7:0] r;
        r = v - 8'h01;
        rf.poke(a, v);
        issue({6'h03, d, a});
        check(rf_rd_addr, a);
        @(posedge aclk);
        #1;
        check(file_wr.en, d);
        check(acc_wr.en, !d);
        if (d) check({file_wr.addr, file_wr.data}, {a, r});
        else check(acc_wr.data, r);
        check(status_wr, {1'b1, r == 8'h00, 3'b000});
        @(posedge aclk);
        #1;
        check(rf.mem[a], d ? r : v);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(wcd_pkg::ADDR_CTRL, 32'h1, 2'h0);
        rd_chk(wcd_pkg::ADDR_STATUS, 32'h0, 2'h0);
        t_clear();
        t_clear();
        t_dec(7'h00, 1'b1, 8'h00);
        t_dec(7'h7F, 1'b0, 8'h01);
        t_dec(7'h7F, 1'b1, 8'h01);
        t_dec(7'h05, 1'b0, 8'h80);
        t_near();
        rd_chk(wcd_pkg::ADDR_WDT_CLR_CNT, 32'h2, 2'h0);
        rd_chk(wcd_pkg::ADDR_DEC_CNT, 32'h4, 2'h0);
        rd_chk(wcd_pkg::ADDR_LAST_DEC, 32'h057F, 2'h0);
        rd_chk(8'h20, 32'h0, 2'h2);
        axi_wr(wcd_pkg::ADDR_CTRL, 32'h0, 2'h0);
        @(posedge aclk);
        #1;
        check(instr_ready, 1'b0);
        axi_wr(wcd_pkg::ADDR_CTRL, 32'h3, 2'h0);
        axi_wr(8'h20, 32'h3, 2'h2);
        t_clear();
        rd_chk(wcd_pkg::ADDR_WDT_CLR_CNT, 32'h1, 2'h0);
        finish_test();
    end
endmodule
